// [rtl/rwd_pkg.sv]
// Purpose: Shared constants and types for the runaway watchdog and reset.
// Assumes: 25 MHz reference clock, AHB-Lite register access.
// Notes:   Control register fields are packed from bit 5 down to bit 0.
package rwd_pkg;

    // ************************************************************
    // Bus and register map
    // ************************************************************
    localparam int          ADDR_W         = 16;
    localparam logic [15:0] WDT_CTRL_OFS   = 16'h7F0C;
    localparam int          HTRANS_ACT_BIT = 1;
    localparam logic        HRESP_OKAY     = 1'b0;

    // ************************************************************
    // Control register layout and reset values
    // ************************************************************
    localparam int          CTRL_W         = 6;
    localparam logic [5:0]  CTRL_RST       = 6'h00;
    localparam int          BIT_START      = 0;
    localparam int          BIT_RUNAWAY    = 1;
    localparam int          BIT_SPARE      = 2;
    localparam int          BIT_STBY_STOP  = 3;
    localparam int          BIT_WDT_RST    = 4;
    localparam int          BIT_ACTION     = 5;

    // ************************************************************
    // Counter, vectors and timing
    // ************************************************************
    localparam int          CNT_W          = 3;
    localparam logic [2:0]  CNT_MAX        = 3'h7;
    localparam logic [2:0]  CNT_ZERO       = 3'h0;
    localparam logic [23:0] RESET_VECTOR   = 24'h008000;
    localparam logic [15:0] SP_RESET       = 16'h0000;
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          RST_PIN_MIN_NS = 10000;
    // Least time, rounded up to whole cycles
    localparam int          RST_HOLD_CYC   =
        (RST_PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          HOLD_W         = 16;

    typedef enum logic {
        PH_RUN,
        PH_RESET
    } rwd_phase_e;

    typedef struct packed {
        logic action_reset;
        logic wdt_rst_flag;
        logic standby_stop;
        logic spare_flag;
        logic runaway;
        logic start;
    } rwd_ctrl_s;

    typedef struct packed {
        rwd_ctrl_s          ctrl;
        logic [CNT_W-1:0]   cnt;
        rwd_phase_e         phase;
        logic [HOLD_W-1:0]  hold;
        logic               pin_s1;
        logic               pin_s2;
        logic               dp_wr;
        logic               dp_hit;
        logic [31:0]        hrdata;
        logic               irq;
        logic               sel_rc;
        logic [23:0]        vector;
        logic [15:0]        sp_init;
    } rwd_state_s;

endpackage

// [rtl/rwd_watchdog.sv]
// Purpose: Reset generation and runaway watchdog with one control register.
// Assumes: Inputs other than i_rst_n and i_reset_pin_n synchronous to i_ref_clk; base timer pulses one cycle.
// Notes:   Zero wait state AHB-Lite slave; unmapped reads return zero.
//
// Function
// R1 - External circuit holds reset pin low at least 10 us after supply.
// R2 - A software reset instruction also resets the device.
// R3 - Every reset source yields a reset synchronised to the system clock.
// R4 - Any reset selects the internal RC oscillator as system clock.
// R5 - Reset clears the stack pointer; data RAM is never initialised.
// R6 - Watchdog core is a 3-bit up counter stepped by base timer pulses.
// R7 - Wrap from maximum to zero is the runaway overflow.
// R8 - Overflow sets the runaway flag at bit 1.
// R9 - Bit 5 selects overflow action: 1 reset, 0 interrupt.
// R10 - Reset mode loads PC with 008000H and resets peripheral registers.
// R11 - Watchdog reset keeps bits 5 to 2 and clears bits 1 and 0.
// R12 - Interrupt mode raises vectored interrupt, counting continues, flag set.
// R13 - Watchdog or improper-start reset sets bit 4, never cleared by them.
// R14 - With bit 3 set, standby entry clears start and stops counting.
// R15 - Writing start 1 starts the watchdog and locks the register.
// R16 - Start cleared by pin, reset overflow, software reset, stopped standby.
// R17 - Software always writes zero to bits 7 and 6.
// R18 - Bit 2 is a plain software flag with no hardware effect.
// R19 - Starting with base timer stopped or its oscillator off resets.
// R20 - Software runs the base timer before starting the watchdog.
// R21 - Only the bit-clear of bit 0 clears the running counter.
`timescale 1ns/1ps

module rwd_watchdog #(
    parameter int RST_HOLD = rwd_pkg::RST_HOLD_CYC
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rst_n,
    input  wire logic                       i_hsel,
    input  wire logic [rwd_pkg::ADDR_W-1:0] i_haddr,
    input  wire logic [1:0]                 i_htrans,
    input  wire logic                       i_hwrite,
    input  wire logic [2:0]                 i_hsize,
    input  wire logic [31:0]                i_hwdata,
    input  wire logic                       i_hready,
    output logic [31:0]                     o_hrdata,
    output logic                            o_hreadyout,
    output logic                            o_hresp,
    input  wire logic                       i_reset_pin_n,
    input  wire logic                       i_sw_reset,
    input  wire logic                       i_bitclr_start,
    input  wire logic                       i_base_tick,
    input  wire logic                       i_base_run,
    input  wire logic                       i_base_osc_en,
    input  wire logic                       i_standby_enter,
    input  wire logic                       i_clk_switch_req,
    output logic                            o_sys_rst_n,
    output logic                            o_periph_rst_n,
    output logic                            o_sel_rc_clk,
    output logic                            o_wdt_irq,
    output logic [23:0]                     o_pc_vector,
    output logic [15:0]                     o_sp_init
);

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic logic ctrl_hit(input logic [rwd_pkg::ADDR_W-1:0] a);
        ctrl_hit = (a[rwd_pkg::ADDR_W-1:2] ==
                    rwd_pkg::WDT_CTRL_OFS[rwd_pkg::ADDR_W-1:2]);
    endfunction

    rwd_pkg::rwd_state_s st_r;
    rwd_pkg::rwd_state_s st_nxt;

    logic addr_ph;
    logic wr_go;
    logic pin_low;
    logic ovf;
    logic bad_start;
    logic wdt_rst;
    logic any_rst;

    assign addr_ph = i_hsel && i_hready && i_htrans[rwd_pkg::HTRANS_ACT_BIT];
    // Writes are ignored once the watchdog runs
    // R15 write lock
    assign wr_go   = st_r.dp_wr && st_r.dp_hit && !st_r.ctrl.start;
    // R1 pin sampled
    assign pin_low = !st_r.pin_s2;
    // R7 wrap is overflow
    assign ovf     = st_r.ctrl.start && i_base_tick && !i_bitclr_start &&
                     (st_r.cnt == rwd_pkg::CNT_MAX);
    // R19 improper start
    assign bad_start = wr_go && i_hwdata[rwd_pkg::BIT_START] &&
                       (!i_base_run || !i_base_osc_en);
    // R9 action select
    assign wdt_rst = (ovf && st_r.ctrl.action_reset) || bad_start;
    assign any_rst = pin_low || wdt_rst || i_sw_reset;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        st_nxt        = st_r;
        st_nxt.irq    = 1'b0;
        st_nxt.pin_s1 = i_reset_pin_n;
        st_nxt.pin_s2 = st_r.pin_s1;

        // Bus address phase capture
        if (i_hready) begin
            st_nxt.dp_wr  = addr_ph && i_hwrite;
            st_nxt.dp_hit = addr_ph && ctrl_hit(i_haddr);
        end

        // R18 spare flag plain
        // R17 upper bits dropped
        if (wr_go) begin
            st_nxt.ctrl = rwd_pkg::rwd_ctrl_s'(
                i_hwdata[rwd_pkg::CTRL_W-1:0]);
        end

        // R6 three bit counter
        // R21 only bit clear
        if (!st_r.ctrl.start || i_bitclr_start) begin
            st_nxt.cnt = rwd_pkg::CNT_ZERO;
        end else if (i_base_tick) begin
            st_nxt.cnt = st_r.cnt + 3'h1;
        end

        // R8 runaway flag
        // R12 interrupt mode
        if (ovf && !st_r.ctrl.action_reset) begin
            st_nxt.ctrl.runaway = 1'b1;
            st_nxt.irq          = 1'b1;
        end

        // R14 standby stop
        if (i_standby_enter && st_r.ctrl.standby_stop) begin
            st_nxt.ctrl.start = 1'b0;
            st_nxt.cnt        = rwd_pkg::CNT_ZERO;
        end

        // R2 software reset
        // R16 start cleared
        if (i_sw_reset) begin
            st_nxt.ctrl.runaway = 1'b0;
            st_nxt.ctrl.start   = 1'b0;
            st_nxt.cnt          = rwd_pkg::CNT_ZERO;
        end

        // R11 keep bits 5..2
        // R13 reset flag set
        if (wdt_rst) begin
            st_nxt.ctrl.wdt_rst_flag = 1'b1;
            st_nxt.ctrl.runaway      = 1'b0;
            st_nxt.ctrl.start        = 1'b0;
            st_nxt.cnt               = rwd_pkg::CNT_ZERO;
        end

        // Pin reset wins over every other source
        if (pin_low) begin
            st_nxt.ctrl = rwd_pkg::rwd_ctrl_s'(rwd_pkg::CTRL_RST);
            st_nxt.cnt  = rwd_pkg::CNT_ZERO;
        end

        // R3 synchronous reset hold
        // Hold stretches short pulses to a full reset
        if (any_rst) begin
            st_nxt.phase = rwd_pkg::PH_RESET;
            st_nxt.hold  = rwd_pkg::HOLD_W'(RST_HOLD - 1);
        end else if (st_r.phase == rwd_pkg::PH_RESET) begin
            if (st_r.hold == '0) begin
                st_nxt.phase = rwd_pkg::PH_RUN;
            end else begin
                st_nxt.hold = st_r.hold - 1'b1;
            end
        end

        // R4 RC clock on reset
        if (any_rst) begin
            st_nxt.sel_rc = 1'b1;
        end else if (i_clk_switch_req && st_r.phase == rwd_pkg::PH_RUN) begin
            st_nxt.sel_rc = 1'b0;
        end

        // R10 PC vector
        // R5 stack pointer zero
        st_nxt.vector  = rwd_pkg::RESET_VECTOR;
        st_nxt.sp_init = rwd_pkg::SP_RESET;

        // Read data uses the next value so a write just ahead is seen
        if (addr_ph && !i_hwrite) begin
            if (ctrl_hit(i_haddr)) begin
                st_nxt.hrdata = {26'h0000000, st_nxt.ctrl};
            end else begin
                st_nxt.hrdata = 32'h00000000;
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r.ctrl    <= rwd_pkg::rwd_ctrl_s'(rwd_pkg::CTRL_RST);
            st_r.cnt     <= rwd_pkg::CNT_ZERO;
            st_r.phase   <= rwd_pkg::PH_RESET;
            st_r.hold    <= rwd_pkg::HOLD_W'(RST_HOLD - 1);
            st_r.pin_s1  <= 1'b0;
            st_r.pin_s2  <= 1'b0;
            st_r.dp_wr   <= 1'b0;
            st_r.dp_hit  <= 1'b0;
            st_r.hrdata  <= 32'h00000000;
            st_r.irq     <= 1'b0;
            st_r.sel_rc  <= 1'b1;
            st_r.vector  <= rwd_pkg::RESET_VECTOR;
            st_r.sp_init <= rwd_pkg::SP_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_hrdata       = st_r.hrdata;
    assign o_hreadyout    = 1'b1;
    assign o_hresp        = rwd_pkg::HRESP_OKAY;
    assign o_sys_rst_n    = (st_r.phase == rwd_pkg::PH_RUN);
    // Interrupt mode never touches peripheral registers
    assign o_periph_rst_n = (st_r.phase == rwd_pkg::PH_RUN);
    assign o_sel_rc_clk   = st_r.sel_rc;
    assign o_wdt_irq      = st_r.irq;
    assign o_pc_vector    = st_r.vector;
    assign o_sp_init      = st_r.sp_init;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_cnt_wrap: assert property ( // R7
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (st_r.ctrl.start && i_base_tick && !i_bitclr_start &&
         st_r.cnt == rwd_pkg::CNT_MAX)
        |=> (st_r.cnt == rwd_pkg::CNT_ZERO))
        else $error("counter did not wrap to zero");

    a_cnt_step: assert property ( // R6
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (st_r.ctrl.start && i_base_tick && !i_bitclr_start &&
         !i_standby_enter && !i_sw_reset && st_r.pin_s2 &&
         st_r.cnt != rwd_pkg::CNT_MAX)
        |=> (st_r.cnt == $past(st_r.cnt) + 3'h1))
        else $error("counter did not step on base tick");

    a_cnt_hold: assert property ( // R21
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (st_r.ctrl.start && !i_base_tick && !i_bitclr_start &&
         !i_standby_enter && !i_sw_reset && st_r.pin_s2)
        |=> (st_r.cnt == $past(st_r.cnt)))
        else $error("counter changed without tick or clear");

    a_irq_mode: assert property ( // R12
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (ovf && !st_r.ctrl.action_reset && !i_sw_reset && st_r.pin_s2 &&
         !i_standby_enter)
        |=> (o_wdt_irq && st_r.ctrl.runaway && st_r.ctrl.start &&
             !$fell(o_periph_rst_n)))
        else $error("interrupt mode overflow handled wrongly");

    a_rst_mode: assert property ( // R11
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (ovf && st_r.ctrl.action_reset && st_r.pin_s2)
        |=> (!o_sys_rst_n && st_r.ctrl.wdt_rst_flag &&
             !st_r.ctrl.runaway && !st_r.ctrl.start &&
             st_r.ctrl.action_reset && !o_wdt_irq))
        else $error("reset mode overflow handled wrongly");

    a_write_lock: assert property ( // R15
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (st_r.ctrl.start && st_r.dp_wr && st_r.dp_hit && !ovf &&
         !i_standby_enter && !i_sw_reset && st_r.pin_s2)
        |=> (st_r.ctrl == $past(st_r.ctrl)))
        else $error("write changed a locked control register");

    a_bad_start: assert property ( // R19
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_go && i_hwdata[rwd_pkg::BIT_START] && st_r.pin_s2 &&
         (!i_base_run || !i_base_osc_en))
        |=> (!o_sys_rst_n && st_r.ctrl.wdt_rst_flag && !st_r.ctrl.start))
        else $error("improper start did not reset");

    a_rst_hold: assert property ( // R3
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        $fell(o_sys_rst_n) |-> (!o_sys_rst_n && o_sel_rc_clk) [*8])
        else $error("reset released too early");

    a_sw_reset: assert property ( // R16
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_sw_reset |=> (!o_sys_rst_n && !st_r.ctrl.start &&
                        !st_r.ctrl.runaway))
        else $error("software reset did not take effect");

    a_stby_stop: assert property ( // R14
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_standby_enter && st_r.ctrl.standby_stop)
        |=> (!st_r.ctrl.start && st_r.cnt == rwd_pkg::CNT_ZERO))
        else $error("standby did not stop the watchdog");

    a_rc_select: assert property ( // R4
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !o_sys_rst_n |-> o_sel_rc_clk)
        else $error("RC clock not selected during reset");

    a_flag_sticky: assert property ( // R13
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (st_r.ctrl.wdt_rst_flag && st_r.pin_s2 && !wr_go)
        |=> st_r.ctrl.wdt_rst_flag)
        else $error("watchdog reset flag lost without a write");

    a_pin_clear: assert property ( // R16
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !st_r.pin_s2
        |=> (!o_sys_rst_n &&
             st_r.ctrl == rwd_pkg::rwd_ctrl_s'(rwd_pkg::CTRL_RST)))
        else $error("pin reset did not clear the control register");

    a_stby_keep: assert property ( // R14
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_standby_enter && !st_r.ctrl.standby_stop && st_r.ctrl.start &&
         !i_sw_reset && !wdt_rst && st_r.pin_s2)
        |=> st_r.ctrl.start)
        else $error("standby without stop select halted the watchdog");

    a_vector_fixed: assert property ( // R10
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !o_sys_rst_n |-> (o_pc_vector == rwd_pkg::RESET_VECTOR &&
                          o_sp_init == rwd_pkg::SP_RESET))
        else $error("reset vector or stack pointer value wrong");

    a_clk_switch: assert property ( // R4
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_switch_req && o_sys_rst_n && !any_rst) |=> !o_sel_rc_clk)
        else $error("clock switch request ignored");

    a_spare_write: assert property ( // R18
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_go && st_r.pin_s2)
        |=> (st_r.ctrl.spare_flag == $past(i_hwdata[rwd_pkg::BIT_SPARE])))
        else $error("spare flag did not take the written value");

endmodule

// [sim/tb_runaway_watchdog_reset.sv]
// Purpose: Self-checking bench for the runaway watchdog and reset block.
// Assumes: Zero-wait bus slave; shortened reset hold for a brief run.
// Notes:   Expected register contents are set by hand in m before each read.
`timescale 1ns/1ps

module tb_runaway_watchdog_reset;

    // ************************************************************
    // Signals and design instance
    // ************************************************************
    localparam int      HOLD  = 9;
    localparam int      BOUND = 200;
    logic               clk   = 1'b0;
    logic               rst_n = 1'b0;
    logic               hsel = 1'b0, hwrite = 1'b0;
    logic [15:0]        haddr = 16'h0000;
    logic [1:0]         htrans = 2'h0;
    logic [2:0]         hsize = 3'h2;
    logic [31:0]        hwdata = 32'h0000_0000;
    logic [31:0]        hrdata, rd;
    logic               hready, hresp;
    logic               pin_n = 1'b1, sw = 1'b0, clr = 1'b0;
    logic               tick = 1'b0, run = 1'b1, osc = 1'b1;
    logic               stby = 1'b0, csw = 1'b0;
    logic               sys_rst_n, per_rst_n, sel_rc, irq;
    logic [23:0]        pc_vec;
    logic [15:0]        sp_init;
    int                 num_errors = 0;
    int                 checked = 0;
    int                 irq_cnt = 0;
    int                 m;

    rwd_watchdog #(.RST_HOLD(HOLD)) DUT (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_reset_pin_n(pin_n), .i_sw_reset(sw), .i_bitclr_start(clr),
        .i_base_tick(tick), .i_base_run(run), .i_base_osc_en(osc),
        .i_standby_enter(stby), .i_clk_switch_req(csw),
        .o_sys_rst_n(sys_rst_n), .o_periph_rst_n(per_rst_n),
        .o_sel_rc_clk(sel_rc), .o_wdt_irq(irq), .o_pc_vector(pc_vec),
        .o_sp_init(sp_init)
    );

    always #20 clk = ~clk;

    // Counting pulses avoids guessing the exact cycle of the interrupt
    always @(posedge clk) begin
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        n = 0;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin num_errors++; tally_and_finish(); end
        htrans <= 2'h0; hwdata <= d;
        n = 0;
        do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin num_errors++; tally_and_finish(); end
        rd = hrdata;
        hsel <= 1'b0;
        chk(32'(hresp), 32'h0);
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: sw <= 1'b1;
            1: clr <= 1'b1;
            2: tick <= 1'b1;
            3: stby <= 1'b1;
            default: csw <= 1'b1;
        endcase
        @(posedge clk);
        sw <= 1'b0; clr <= 1'b0; tick <= 1'b0; stby <= 1'b0; csw <= 1'b0;
    endtask

    task automatic ticks(input int k);
        repeat (k) begin
            repeat ($urandom % 3) @(posedge clk);
            pulse(2);
        end
    endtask

    task automatic rst_seen;
        @(posedge clk); #1;
        chk(32'(sys_rst_n), 32'h0);
        chk(32'(per_rst_n), 32'h0);
    endtask

    task automatic wait_rel;
        int n;
        n = 0;
        while (sys_rst_n !== 1'b1 && n < BOUND) begin @(posedge clk); n++; end
        if (n >= BOUND) begin num_errors++; tally_and_finish(); end
    endtask

    task automatic rd_chk;
        bus(1'b0, rwd_pkg::WDT_CTRL_OFS, 32'h0);
        chk(rd, 32'(m));
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'hb5bbc760));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wait_rel();
        chk(32'(sel_rc), 32'h1);
        chk(32'(sp_init), 32'h0);
        chk(32'(pc_vec), 32'h0000_8000);
        m = 0;
        rd_chk();
        m = ($urandom % 2) << 2;
        bus(1'b1, rwd_pkg::WDT_CTRL_OFS, 32'(m));
        rd_chk();
        bus(1'b1, rwd_pkg::WDT_CTRL_OFS, 32'h0);
        bus(1'b0, 16'h7F10, 32'h0);
        chk(rd, 32'h0);
        // Start with the base timer stopped
        run <= 1'b0;
        bus(1'b1, rwd_pkg::WDT_CTRL_OFS, 32'h01);
        rst_seen();
        m = 32'h10;
        rd_chk();
        run <= 1'b1;
        wait_rel();
        // Start with the timer oscillator off
        osc <= 1'b0;
        bus(1'b1, rwd_pkg::WDT_CTRL_OFS, 32'h01);
        rst_seen();
        rd_chk();
        osc <= 1'b1;
        wait_rel();
        // Interrupt mode, locked register, clear before the wrap
        bus(1'b1, rwd_pkg::WDT_CTRL_OFS, 32'h01);
        m = 32'h01;
        bus(1'b1, rwd_pkg::WDT_CTRL_OFS, 32'h00);
        rd_chk();
        ticks(7);
        pulse(1);
        ticks(7);
        repeat (3) @(posedge clk);
        chk(32'(irq_cnt), 32'h0);
        ticks(1);
        repeat (3) @(posedge clk);
        chk(32'(irq_cnt), 32'h1);
        chk(32'(sys_rst_n), 32'h1);
        m = 32'h03;
        rd_chk();
        pulse(0);
        rst_seen();
        m = 32'h00;
        rd_chk();
        wait_rel();
        // Standby with and without the stop select
        bus(1'b1, rwd_pkg::WDT_CTRL_OFS, 32'h19);
        pulse(3);
        m = 32'h18;
        rd_chk();
        bus(1'b1, rwd_pkg::WDT_CTRL_OFS, 32'h11);
        pulse(3);
        m = 32'h11;
        rd_chk();
        pulse(0);
        rst_seen();
        wait_rel();
        // Leave the RC clock; the coming reset must bring it back
        pulse(4);
        #1;
        chk(32'(sel_rc), 32'h0);
        // upper bits written zero
        // Reset mode overflow keeps the upper fields
        bus(1'b1, rwd_pkg::WDT_CTRL_OFS, 32'h25);
        ticks(8);
        rst_seen();
        m = 32'h34;
        rd_chk();
        wait_rel();
        chk(32'(sel_rc), 32'h1);
        // Short pin pulse still resets everything
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk(32'(sys_rst_n), 32'h0);
        pin_n <= 1'b1;
        m = 0;
        rd_chk();
        wait_rel();
        // pin held for the full minimum time
        pin_n <= 1'b0;
        repeat (rwd_pkg::RST_HOLD_CYC) @(posedge clk);
        chk(32'(sys_rst_n), 32'h0);
        pin_n <= 1'b1;
        wait_rel();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end

endmodule
